// [hw/bfc_flash_regs.sv]
/*
  Boost level, boost frequency and flash control registers with the
  flash sequencer. Registers are reached through the decoded register
  port of the device's serial host interface. Power stages sit outside
  and take the decoded outputs.
  Assumes all inputs are synchronous to clk_in.
*/
// How it works
// - Boost level read as thermometer step count
// - Boost level resets to 0x3f, fully read/write
// - Frequency select decodes 1xx/01x/00x, resets ones
// - Bit 5 gates PWM onto flash drive
// - Timed flashes last 200, 400 or 600 ms
// - Code 11 follows trigger pin while held
// - Current field scales flash to quarters
// - Flash control resets zero, bits 7-6 read zero
// - Bit 0 enables the flash driver
`timescale 1ns/100ps
module bfc_flash_regs #(
  parameter int unsigned CYC_200 = bfc_pkg::DUR_200_CYCLES,
  parameter int unsigned CYC_400 = bfc_pkg::DUR_400_CYCLES,
  parameter int unsigned CYC_600 = bfc_pkg::DUR_600_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic reg_wr_en_in,
  input wire logic reg_rd_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic flash_trigger_pin_in,
  input wire logic flash_pwm_wave_in,
  output logic [7:0] boost_level_out,
  output logic [3:0] boost_step_out,
  output bfc_pkg::bfc_freq_type boost_freq_out,
  output logic flash_driver_enable_out,
  output logic [1:0] flash_current_level_out,
  output logic flash_on_out,
  output logic flash_drive_out
);
  import bfc_pkg::*;

  localparam int W = TIMER_W;

  // Whole block state
  typedef struct packed {
    logic [7:0] boost_level; // Thermometer boost target
    logic [2:0] freq_sel; // Switching frequency select
    logic [5:0] flash_ctrl; // Implemented flash control bits
    logic [7:0] rdata; // Registered read answer
    logic trig_prev; // Trigger pin, last cycle
    bfc_flash_state_type fsm; // Flash sequencer
    logic [3:0] step; // Decoded boost step
    bfc_freq_type freq; // Decoded frequency
    logic flash_on; // Flash phase active
    logic drive; // Flash drive after PWM gating
    logic [W-1:0] on_len; // Cycles of current timed flash
    logic [W-1:0] run_len; // Length latched at flash start
  } bfc_state_type;

  bfc_state_type q, d;

  logic wr_level, wr_freq, wr_flash;
  logic flash_en, pwm_en, trig_rise;
  logic [1:0] dur_sel;
  logic [W-1:0] timer_load;
  logic [W-1:0] dur_len;
  logic timer_start, timer_stop, timer_running, timer_expired;

  // Write decode and field views
  always_comb begin
    wr_level = reg_wr_en_in && (reg_addr_in == ADDR_BOOST_LEVEL);
    wr_freq = reg_wr_en_in && (reg_addr_in == ADDR_BOOST_FREQ);
    wr_flash = reg_wr_en_in && (reg_addr_in == ADDR_FLASH_CTRL);
    flash_en = q.flash_ctrl[FL_EN_BIT];
    pwm_en = q.flash_ctrl[FL_PWM_BIT];
    dur_sel = q.flash_ctrl[FL_DUR_MSB:FL_DUR_LSB];
    trig_rise = flash_trigger_pin_in && !q.trig_prev;
  end

  // Duration length by select code; pin mode needs no timer
  always_comb begin
    case (dur_sel)
      DUR_200: dur_len = W'(CYC_200);
      DUR_400: dur_len = W'(CYC_400);
      DUR_600: dur_len = W'(CYC_600);
      default: dur_len = W'(CYC_200);
    endcase
    // Preload short by two so the flash lasts the full length
    timer_load = dur_len - W'(TIMER_PRELOAD_SLACK);
  end

  // Timer is started on a trigger edge in a timed mode only
  always_comb begin
    timer_start = (q.fsm == FL_IDLE) && flash_en && trig_rise &&
                  (dur_sel != DUR_PIN);
    timer_stop = (q.fsm == FL_TIMED) && !flash_en;
  end

  bfc_duration_timer #(
    .CNT_W(W)
  ) u_timer (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .start_in(timer_start),
    .stop_in(timer_stop),
    .load_in(timer_load),
    .running_out(timer_running),
    .expired_out(timer_expired)
  );

  // Next-state logic for registers, read port and sequencer
  always_comb begin
    d = q;
    d.trig_prev = flash_trigger_pin_in;
    // Register writes
    if (wr_level) begin
      d.boost_level = reg_wdata_in;
    end
    if (wr_freq) begin
      d.freq_sel = reg_wdata_in[2:0];
    end
    if (wr_flash) begin
      d.flash_ctrl = reg_wdata_in[5:0];
    end
    // Reads answer one cycle later; unused bits and holes read zero
    if (reg_rd_en_in) begin
      case (reg_addr_in)
        ADDR_BOOST_LEVEL: d.rdata = q.boost_level;
        ADDR_BOOST_FREQ: d.rdata = {5'h00, q.freq_sel};
        ADDR_FLASH_CTRL: d.rdata = {2'h0, q.flash_ctrl};
        default: d.rdata = RDATA_UNMAPPED;
      endcase
    end
    // Decoded boost outputs follow the stored fields
    d.step = bfc_trail_ones(d.boost_level);
    if (d.freq_sel[FREQ_TOP_BIT]) begin
      d.freq = FREQ_2M00;
    end else if (d.freq_sel[FREQ_MID_BIT]) begin
      d.freq = FREQ_1M67;
    end else begin
      d.freq = FREQ_1M00;
    end
    // Flash sequencer
    case (q.fsm)
      FL_IDLE: begin
        if (flash_en && dur_sel == DUR_PIN && flash_trigger_pin_in) begin
          d.fsm = FL_PIN;
        end else if (timer_start) begin
          d.fsm = FL_TIMED;
        end
      end
      FL_TIMED: begin
        // Clearing the enable cuts a flash short at once
        if (!flash_en || timer_expired) begin
          d.fsm = FL_IDLE;
        end
      end
      FL_PIN: begin
        if (!flash_en || !flash_trigger_pin_in) begin
          d.fsm = FL_IDLE;
        end
      end
      default: d.fsm = FL_IDLE;
    endcase
    d.flash_on = (d.fsm != FL_IDLE);
    // PWM wave chops the drive only when enabled
    d.drive = d.flash_on && (!d.flash_ctrl[FL_PWM_BIT] ||
                             flash_pwm_wave_in);
    d.on_len = (d.fsm == FL_TIMED) ? q.on_len + W'(1) : '0;
    // Length held so a later select change cannot stretch the bound
    if (timer_start) begin
      d.run_len = dur_len;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q.boost_level <= BOOST_LEVEL_RESET;
      q.freq_sel <= FREQ_SEL_RESET;
      q.flash_ctrl <= FLASH_CTRL_RESET;
      q.rdata <= RDATA_UNMAPPED;
      q.trig_prev <= 1'b0;
      q.fsm <= FL_IDLE;
      q.step <= 4'h6;
      q.freq <= FREQ_2M00;
      q.flash_on <= 1'b0;
      q.drive <= 1'b0;
      q.on_len <= '0;
      q.run_len <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state flops
  assign reg_rdata_out = q.rdata;
  assign boost_level_out = q.boost_level;
  assign boost_step_out = q.step;
  assign boost_freq_out = q.freq;
  assign flash_driver_enable_out = q.flash_ctrl[FL_EN_BIT];
  assign flash_current_level_out = q.flash_ctrl[FL_CUR_MSB:FL_CUR_LSB];
  assign flash_on_out = q.flash_on;
  assign flash_drive_out = q.drive;

  chk_boost_step: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    boost_step_out == bfc_trail_ones(boost_level_out))
    else $error("boost step does not match level");

  chk_level_write: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    wr_level |=> boost_level_out == $past(reg_wdata_in))
    else $error("boost level write lost");

  chk_freq_decode: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    (q.freq_sel[2] -> boost_freq_out == FREQ_2M00) &&
    (q.freq_sel[2:1] == 2'h1 -> boost_freq_out == FREQ_1M67) &&
    (q.freq_sel[2:1] == 2'h0 -> boost_freq_out == FREQ_1M00))
    else $error("frequency decode wrong");

  chk_freq_upper: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    reg_rd_en_in && reg_addr_in == ADDR_BOOST_FREQ
    |=> reg_rdata_out[7:3] == 5'h00)
    else $error("frequency upper bits not zero");

  chk_pwm_off: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    !q.flash_ctrl[FL_PWM_BIT] && flash_on_out |-> flash_drive_out)
    else $error("drive chopped with pwm disabled");

  chk_timed_bound: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    q.fsm == FL_TIMED |-> q.on_len <= q.run_len)
    else $error("timed flash ran past its length");

  // Last counted cycle of a timed flash is followed by dark
  chk_timed_exact: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    q.fsm == FL_TIMED && q.on_len == q.run_len |=> !flash_on_out)
    else $error("timed flash outlived its length");

  chk_pin_release: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    q.fsm == FL_PIN && !flash_trigger_pin_in |=> !flash_on_out)
    else $error("pin flash outlived the pin");

  chk_current_write: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    wr_flash |=> flash_current_level_out == $past(reg_wdata_in[2:1]))
    else $error("current level write lost");

  chk_flash_upper: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    reg_rd_en_in && reg_addr_in == ADDR_FLASH_CTRL
    |=> reg_rdata_out[7:6] == 2'h0)
    else $error("flash control upper bits not zero");

  chk_enable_gate: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    !flash_driver_enable_out |=> !flash_on_out)
    else $error("flash on while driver disabled");

  chk_timer_pair: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    q.fsm == FL_TIMED && flash_en |-> timer_running || timer_expired)
    else $error("timed flash without a running timer");

endmodule

// [hw/bfc_pkg.sv]
/*
  Shared constants for the boost and flash control register bank:
  register offsets, field positions, reset values, codes and timing.
  Assumes a 125 MHz device clock; the cycle counts derive from it here.
*/
package bfc_pkg;

  // Register offsets on the device register port
  localparam logic [7:0] ADDR_BOOST_LEVEL = 8'h0d;
  localparam logic [7:0] ADDR_BOOST_FREQ = 8'h0e;
  localparam logic [7:0] ADDR_FLASH_CTRL = 8'h10;

  // Reset values
  localparam logic [7:0] BOOST_LEVEL_RESET = 8'h3f;
  localparam logic [2:0] FREQ_SEL_RESET = 3'h7;
  localparam logic [5:0] FLASH_CTRL_RESET = 6'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // Flash control and frequency select field positions
  localparam int FL_PWM_BIT = 5;
  localparam int FL_DUR_MSB = 4;
  localparam int FL_DUR_LSB = 3;
  localparam int FL_CUR_MSB = 2;
  localparam int FL_CUR_LSB = 1;
  localparam int FL_EN_BIT = 0;
  localparam int FREQ_TOP_BIT = 2;
  localparam int FREQ_MID_BIT = 1;

  // Flash duration codes
  localparam logic [1:0] DUR_200 = 2'h0;
  localparam logic [1:0] DUR_400 = 2'h1;
  localparam logic [1:0] DUR_600 = 2'h2;
  localparam logic [1:0] DUR_PIN = 2'h3;

  // Timing: printed times in ms, cycle counts derived from the clock
  localparam int unsigned CLK_FREQ_KHZ = 125000;
  localparam int unsigned DUR_200_MS = 200;
  localparam int unsigned DUR_400_MS = 400;
  localparam int unsigned DUR_600_MS = 600;
  localparam int unsigned DUR_200_CYCLES = DUR_200_MS * CLK_FREQ_KHZ;
  localparam int unsigned DUR_400_CYCLES = DUR_400_MS * CLK_FREQ_KHZ;
  localparam int unsigned DUR_600_CYCLES = DUR_600_MS * CLK_FREQ_KHZ;
  localparam int TIMER_W = 27;
  // Timer reloads this much below the length so on-time is exact
  localparam int unsigned TIMER_PRELOAD_SLACK = 2;

  // Decoded switching frequency
  typedef enum logic [1:0] {
    FREQ_1M00 = 2'h0,
    FREQ_1M67 = 2'h1,
    FREQ_2M00 = 2'h2
  } bfc_freq_type;

  // Flash sequencer states, Gray along idle -> timed; idle -> pin flips both bits
  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_TIMED = 2'b01,
    FL_PIN = 2'b11
  } bfc_flash_state_type;

  // Count of consecutive ones from bit 0 of a thermometer code
  function automatic logic [3:0] bfc_trail_ones(input logic [7:0] v);
    logic [3:0] n;
    logic stop;
    n = 4'h0;
    stop = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (!stop && v[i]) begin
        n = n + 4'h1;
      end else begin
        stop = 1'b1;
      end
    end
    return n;
  endfunction

endpackage

// [hw/bfc_duration_timer.sv]
/*
  Flash duration down-counter. Loaded on a start pulse, halted by stop with the count held,
  pulses expired once when the count runs out.
  Assumes start and stop come from the same clock domain.
*/
`timescale 1ns/100ps
module bfc_duration_timer #(
  parameter int CNT_W = 27
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic [CNT_W-1:0] load_in,
  output logic running_out,
  output logic expired_out
);
  import bfc_pkg::*;

  // Whole timer state
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic running;
    logic expired;
  } bfc_timer_state_type;

  bfc_timer_state_type q, d;

  // Next-state logic
  always_comb begin
    d = q;
    d.expired = 1'b0;
    if (start_in) begin
      // Start wins over everything, a fresh flash restarts timing
      d.cnt = load_in;
      d.running = 1'b1;
    end else if (stop_in) begin
      d.running = 1'b0;
    end else if (q.running) begin
      if (q.cnt == '0) begin
        d.running = 1'b0;
        d.expired = 1'b1;
      end else begin
        d.cnt = q.cnt - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign running_out = q.running;
  assign expired_out = q.expired;

  // Expiry only ever follows a running count of zero
  chk_expiry_cause: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    $rose(q.expired) |-> $past(q.running) && $past(q.cnt) == '0)
    else $error("timer expired without running out");

endmodule

// [dv/bfc_flash_stage_model.sv]
/*
  Flash power stage stand-in: makes the PWM chop wave and times each
  flash as the stage sees it. Assumes flash outputs change on clk_in.
*/
`timescale 1ns/100ps
module bfc_flash_stage_model (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic flash_on_in,
  input wire logic flash_drive_in,
  output logic pwm_wave_out,
  output logic [7:0] on_len_out,
  output logic [7:0] drive_len_out
);
  logic [7:0] on_cnt; // Cycles of the flash in progress
  logic [7:0] drv_cnt; // Driven cycles of the same flash
  // Period-two wave: any even window is exactly half driven
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pwm_wave_out <= 1'b0;
      on_cnt <= 8'h00;
      drv_cnt <= 8'h00;
      on_len_out <= 8'h00;
      drive_len_out <= 8'h00;
    end else begin
      pwm_wave_out <= ~pwm_wave_out;
      if (flash_on_in) begin
        // Lamp lit: count on-time and driven time
        on_cnt <= on_cnt + 8'h01;
        drv_cnt <= drv_cnt + {7'h00, flash_drive_in};
      end else if (on_cnt != 8'h00) begin
        // Flash over: hold its lengths for the bench
        on_len_out <= on_cnt;
        drive_len_out <= drv_cnt;
        on_cnt <= 8'h00;
        drv_cnt <= 8'h00;
      end
    end
  end
endmodule

// [dv/bfc_flash_regs_tb.sv]
/*
  Self-checking bench for the boost and flash register bank.
  Assumes the design's register port and short flash durations.
*/
`timescale 1ns/100ps
module bfc_flash_regs_tb;
  import bfc_pkg::*;
  localparam int C1 = 10; // Short stand-ins for the long durations
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin = 1'b0; // Trigger pin, driven by the bench
  logic wave;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata, lvl, on_len, drv_len;
  logic [3:0] step;
  bfc_freq_type freq;
  logic fen, fon, fdrv;
  logic [1:0] cur;
  int miscompares = 0;
  int compares = 0;
  logic [31:0] seed = 32'd60939;
  logic [7:0] e_lvl = 8'h3f; // Mirror of the three registers
  logic [2:0] e_frq = 3'h7;
  logic [5:0] e_fl = 6'h00;
  logic [7:0] a, d, ctl, len;
  logic [1:0] c;

  always #4 clk_in = ~clk_in;

  bfc_flash_regs #(.CYC_200(C1), .CYC_400(2*C1), .CYC_600(3*C1)) u_dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .reg_wr_en_in(wr),
    .reg_rd_en_in(rd), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_rdata_out(rdata), .flash_trigger_pin_in(pin),
    .flash_pwm_wave_in(wave), .boost_level_out(lvl),
    .boost_step_out(step), .boost_freq_out(freq),
    .flash_driver_enable_out(fen), .flash_current_level_out(cur),
    .flash_on_out(fon), .flash_drive_out(fdrv));

  bfc_flash_stage_model u_stage (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .flash_on_in(fon),
    .flash_drive_in(fdrv), .pwm_wave_out(wave), .on_len_out(on_len),
    .drive_len_out(drv_len));

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Thermometer step: ones counted up from bit 0
  function automatic logic [7:0] trail(input logic [7:0] v);
    logic [7:0] n;
    n = 8'h00;
    while (n < 8'h08 && v[n[2:0]]) n++;
    return n;
  endfunction

  function automatic logic [7:0] fdec(input logic [2:0] f);
    return f[2] ? 8'h02 : (f[1] ? 8'h01 : 8'h00);
  endfunction

  // Expected read value, zero where nothing is mapped
  function automatic logic [7:0] expv(input logic [7:0] ad);
    case (ad)
      8'h0d: return e_lvl;
      8'h0e: return {5'h00, e_frq};
      8'h10: return {2'h0, e_fl};
      default: return 8'h00;
    endcase
  endfunction

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One write, mirrored into the expected registers
  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] dat);
    @(negedge clk_in);
    wr = 1'b1;
    addr = ad;
    wd = dat;
    @(negedge clk_in);
    wr = 1'b0;
    wd = ~dat; // Stale data must not matter
    if (ad == 8'h0d) e_lvl = dat;
    if (ad == 8'h0e) e_frq = dat[2:0];
    if (ad == 8'h10) e_fl = dat[5:0];
  endtask

  task automatic rd_chk(input logic [7:0] ad);
    @(negedge clk_in);
    rd = 1'b1;
    addr = ad;
    @(negedge clk_in);
    rd = 1'b0;
    check("read data", rdata, expv(ad));
  endtask

  task automatic outs_chk();
    check("level", lvl, e_lvl);
    check("step", {4'h0, step}, trail(e_lvl));
    check("freq", {6'h00, freq}, fdec(e_frq));
    check("enable", {7'h00, fen}, {7'h00, e_fl[0]});
    check("current", {6'h00, cur}, {6'h00, e_fl[2:1]});
  endtask

  // Trigger held for hold cycles, then wait for the flash to end
  task automatic flash(input logic [7:0] hold);
    int n;
    @(negedge clk_in);
    pin = 1'b1;
    repeat (hold) @(negedge clk_in);
    pin = 1'b0;
    for (n = 0; n < 100 && fon !== 1'b0; n++) @(negedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Hang guard, well beyond the expected run length
  initial begin
    #(8 * 20000);
    miscompares++;
    final_report();
  end

  initial begin
    repeat (6) @(negedge clk_in);
    reset_n_in = 1'b1;
    outs_chk();
    for (int i = 0; i < 3; i++)
      rd_chk(i == 2 ? 8'h10 : 8'h0d + 8'(i));
    // Random traffic, two unmapped offsets among the mapped ones
    repeat (24) begin
      case (xs() % 5)
        0: a = 8'h0d;
        1: a = 8'h0e;
        2: a = 8'h10;
        3: a = 8'h0f;
        default: a = 8'h00;
      endcase
      d = 8'(xs());
      wr_reg(a, d);
      outs_chk();
      rd_chk(a);
    end
    // Mid-run reset must restore every register, not only a clean start
    @(negedge clk_in);
    reset_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    reset_n_in = 1'b1;
    e_lvl = BOOST_LEVEL_RESET;
    e_frq = FREQ_SEL_RESET;
    e_fl = FLASH_CTRL_RESET;
    outs_chk();
    for (int i = 0; i < 3; i++)
      rd_chk(i == 2 ? 8'h10 : 8'h0d + 8'(i));
    // Every frequency select, upper bits written as ones
    for (int f = 0; f < 8; f++) begin
      wr_reg(8'h0e, {5'h1f, 3'(f)});
      outs_chk();
      rd_chk(8'h0e);
    end
    // Every thermometer length from all-zero to all-ones
    for (int k = 0; k < 9; k++) begin
      wr_reg(8'h0d, 8'((9'h001 << k) - 9'h001));
      check("step", {4'h0, step}, 8'(k));
    end
    // Each duration code, chopped and unchopped
    for (int du = 0; du < 4; du++) begin
      for (int p = 0; p < 2; p++) begin
        c = 2'(xs());
        ctl = {2'h0, p[0], du[1:0], c, 1'b1};
        len = (du == 3) ? 8'h08 : 8'(C1 * (du + 1));
        wr_reg(8'h10, ctl);
        check("current", {6'h00, cur}, {6'h00, c});
        flash(du == 3 ? len : 8'h01);
        check("on time", on_len, len);
        check("drive", drv_len, p ? len / 2 : len);
      end
    end
    // Clearing the enable cuts a long flash short
    wr_reg(8'h10, {3'h0, DUR_600, 3'h1});
    @(negedge clk_in);
    pin = 1'b1;
    repeat (5) @(negedge clk_in);
    pin = 1'b0;
    wr_reg(8'h10, 8'h00);
    @(negedge clk_in);
    check("abort", {7'h00, fon}, 8'h00);
    // Trigger with the driver disabled is ignored
    @(negedge clk_in);
    pin = 1'b1;
    repeat (3) @(negedge clk_in);
    check("disabled", {7'h00, fon}, 8'h00);
    pin = 1'b0;
    final_report();
  end
endmodule
